// [hw/core_cfg_regs.sv]
// Indexed configuration bank: clock ratio / half speed, management region,
// lock and map enable, identification. Index and data strobes come from
// processor logic on clock_i; only the ratio strap is asynchronous.
`timescale 1ns/1ns
module core_cfg_regs
   import core_cfg_pkg::*;
#(
   parameter logic [7:0] PART_CODE     = 8'h5a,  // Arbitrary value
   parameter logic [3:0] REVISION_CODE = 4'h1,   // Arbitrary value
   parameter logic [3:0] STEPPING_CODE = 4'h2    // Arbitrary value
)(
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   input  wire logic        ratio_strap_pin_i,
   input  wire logic        mgmt_mode_i,
   input  wire logic        bus_transfer_i,
   input  wire logic        index_wr_i,
   input  wire logic        data_wr_i,
   input  wire logic        data_rd_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       rdata_o,
   output logic             rdata_valid_o,
   output logic [1:0]       core_ratio_o,
   output logic             core_ratio_reserved_o,
   output logic             core_half_o,
   output logic             mgmt_lock_bit_o,
   output logic [3:0]       index_map_enable_o,
   output region_t          mgmt_region_o
);

   cfg_state_t  state;
   cfg_state_t  next_state;
   logic        settling;
   logic        protect_ok;
   logic        index_open;
   logic [7:0]  read_value;
   logic [3:0]  map_en;
   logic        region_en;
   logic [25:0] region_size;

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   assign map_en     = state.config_ctl_three[MAP_EN_LSB +: 4];
   assign settling   = (state.settle_cnt != STRAP_SETTLE_CYC);
   // Locked bits stay open to the management handler
   assign protect_ok = !state.config_ctl_three[LOCK_BIT] || mgmt_mode_i;
   assign index_open = (map_en != 4'h0) || (state.index[7:4] == IDX_ALWAYS_PAGE)
                       || (state.index == IDX_PART_IDENT) || (state.index == IDX_REV_STEP_IDENT);

   always_comb begin
      read_value = 8'h00;
      if (index_open) begin
         case (state.index)
            IDX_CONFIG_CTL_THREE: read_value = state.config_ctl_three;
            IDX_REGION_BYTE_A:    read_value = state.region_a;
            IDX_REGION_BYTE_B:    read_value = state.region_b;
            IDX_REGION_BYTE_C:    read_value = state.region_c;
            IDX_POWER_CTL:        read_value = {5'h00, state.half_speed_en, state.ratio};
            IDX_PART_IDENT:       read_value = PART_CODE;
            IDX_REV_STEP_IDENT:   read_value = {STEPPING_CODE, REVISION_CODE};
            default:              read_value = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_state            = state;
      next_state.strap_meta = ratio_strap_pin_i;
      next_state.strap_sync = state.strap_meta;
      next_state.rvalid     = data_rd_i;
      if (data_rd_i) begin
         next_state.rdata = read_value;
      end
      if (index_wr_i) begin
         next_state.index = wdata_i;
      end
      if (data_wr_i && index_open) begin
         case (state.index)
            IDX_CONFIG_CTL_THREE: begin
               next_state.config_ctl_three[7:2] = wdata_i[7:2];
               if (protect_ok) begin
                  next_state.config_ctl_three[NMI_GUARD_BIT] = wdata_i[NMI_GUARD_BIT];
               end
               // Lock is set-only, even for the handler
               next_state.config_ctl_three[LOCK_BIT] =
                  state.config_ctl_three[LOCK_BIT] | wdata_i[LOCK_BIT];
            end
            IDX_REGION_BYTE_A: if (protect_ok) next_state.region_a = wdata_i;
            IDX_REGION_BYTE_B: if (protect_ok) next_state.region_b = wdata_i;
            IDX_REGION_BYTE_C: if (protect_ok) next_state.region_c = wdata_i;
            IDX_POWER_CTL: begin
               next_state.ratio         = wdata_i[RATIO_LSB +: 2];
               next_state.half_speed_en = wdata_i[HALF_SPEED_BIT];
            end
            default: ;
         endcase
      end
      // Strap sampled for a few cycles after release; a steady pin is assumed
      if (settling) begin
         next_state.settle_cnt = state.settle_cnt + 2'h1;
         next_state.ratio      = state.strap_sync ? RATIO_STRAP_HI : RATIO_STRAP_LOW;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state                  <= '0;
         state.ratio            <= RATIO_STRAP_LOW;
         state.half_speed_en    <= 1'b0;
         state.config_ctl_three <= CONFIG_CTL_THREE_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata_o               = state.rdata;
   assign rdata_valid_o         = state.rvalid;
   assign core_ratio_o          = state.ratio;
   assign core_ratio_reserved_o = (state.ratio == RATIO_RESERVED);
   // Bus transfers run at full ratio; software lowering ratio is its call
   assign core_half_o           = state.half_speed_en && !bus_transfer_i;
   assign mgmt_lock_bit_o       = state.config_ctl_three[LOCK_BIT];
   assign index_map_enable_o    = map_en;
   // One driver for the whole struct; base is address bits 31:12
   assign mgmt_region_o         = {region_en, state.region_a, state.region_b, state.region_c[7:4], region_size};

   region_size_decode u_size (
      .size_code_i  (state.region_c[3:0]),
      .enable_o     (region_en),
      .size_bytes_o (region_size)
   );

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   a_lock_sticky: assert property (mgmt_lock_bit_o |=> mgmt_lock_bit_o)
      else $error("lock bit cleared without reset");
   a_region_guard: assert property (
      (data_wr_i && state.index == IDX_REGION_BYTE_A && mgmt_lock_bit_o && !mgmt_mode_i)
      |=> $stable(state.region_a))
      else $error("locked region byte changed");
   a_handler_write: assert property (
      (data_wr_i && state.index == IDX_REGION_BYTE_B && mgmt_mode_i && index_open)
      |=> state.region_b == $past(wdata_i))
      else $error("handler write to region lost");
   // Ties the stored half speed bit to the output, not the output to itself
   a_half_speed: assert property (
      (data_wr_i && index_open && state.index == IDX_POWER_CTL && wdata_i[HALF_SPEED_BIT])
      |=> (core_half_o || bus_transfer_i))
      else $error("half speed output wrong");
   a_transfer_full: assert property (
      (state.half_speed_en && bus_transfer_i) |-> !core_half_o)
      else $error("half speed during bus transfer");
   a_strap_ratio: assert property (
      (settling && state.settle_cnt == 2'h2) |=>
      core_ratio_o == ($past(state.strap_sync) ? RATIO_STRAP_HI : RATIO_STRAP_LOW))
      else $error("strap ratio not loaded");
   a_part_read: assert property (
      (data_rd_i && state.index == IDX_PART_IDENT) |=> rdata_valid_o && rdata_o == PART_CODE)
      else $error("part code read wrong");
   a_rev_read: assert property (
      (data_rd_i && state.index == IDX_REV_STEP_IDENT) |=>
      rdata_o == {STEPPING_CODE, REVISION_CODE})
      else $error("revision read wrong");
   a_power_rsvd: assert property (
      (data_rd_i && state.index == IDX_POWER_CTL) |=> rdata_o[7:3] == 5'h00)
      else $error("reserved power bits not zero");
   a_map_closed: assert property (
      (data_rd_i && map_en == 4'h0 && state.index == IDX_POWER_CTL) |=> rdata_o == 8'h00)
      else $error("closed index readable");
   a_size_off: assert property (
      (state.region_c[3:0] == SIZE_OFF) |-> !mgmt_region_o.enable)
      else $error("region enabled with size zero");

   c_lock_set:     cover property (!mgmt_lock_bit_o ##1 mgmt_lock_bit_o);
   c_handler_wr:   cover property (data_wr_i && mgmt_mode_i && mgmt_lock_bit_o);
   c_half_burst:   cover property (state.half_speed_en && bus_transfer_i ##1 !bus_transfer_i);
   c_ratio_lowered: cover property (!settling && core_ratio_o == RATIO_ONE);

endmodule

// [hw/core_cfg_pkg.sv]
// Package: index map, field layout, reset values and shared state of the
// core clock / management region / identification register bank.
// Assumes byte-wide index and data accesses from the processor side.
package core_cfg_pkg;

   // Configuration indices
   localparam logic [7:0] IDX_CONFIG_CTL_THREE = 8'hc3;
   localparam logic [7:0] IDX_REGION_BYTE_A    = 8'hcd;
   localparam logic [7:0] IDX_REGION_BYTE_B    = 8'hce;
   localparam logic [7:0] IDX_REGION_BYTE_C    = 8'hcf;
   localparam logic [7:0] IDX_POWER_CTL        = 8'hf0;
   localparam logic [7:0] IDX_PART_IDENT       = 8'hfe;
   localparam logic [7:0] IDX_REV_STEP_IDENT   = 8'hff;
   localparam logic [3:0] IDX_ALWAYS_PAGE      = 4'hc;

   // Power control fields
   localparam int         RATIO_LSB       = 0;
   localparam int         HALF_SPEED_BIT  = 2;
   localparam logic [1:0] RATIO_ONE       = 2'h0;
   localparam logic [1:0] RATIO_TWO       = 2'h1;
   localparam logic [1:0] RATIO_RESERVED  = 2'h2;
   localparam logic [1:0] RATIO_THREE     = 2'h3;
   localparam logic [1:0] RATIO_STRAP_LOW = RATIO_TWO;
   localparam logic [1:0] RATIO_STRAP_HI  = RATIO_THREE;

   // Config control three fields
   localparam int         LOCK_BIT      = 0;
   localparam int         NMI_GUARD_BIT = 1;
   localparam int         MAP_EN_LSB    = 4;
   localparam logic [7:0] CONFIG_CTL_THREE_RESET    = 8'h00;

   // Region size encoding
   localparam logic [3:0] SIZE_OFF      = 4'h0;
   localparam logic [3:0] SIZE_ALIAS    = 4'hf;
   localparam logic [25:0] SIZE_MIN_BYTES = 26'h0001000;

   // Cycles after reset release during which the strap is sampled
   localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

   typedef struct packed {
      logic [7:0] index;
      logic [1:0] ratio;
      logic       half_speed_en;
      logic [7:0] config_ctl_three;
      logic [7:0] region_a;
      logic [7:0] region_b;
      logic [7:0] region_c;
      logic [7:0] rdata;
      logic       rvalid;
      logic       strap_meta;
      logic       strap_sync;
      logic [1:0] settle_cnt;
   } cfg_state_t;

   typedef struct packed {
      logic        enable;
      logic [19:0] base;
      logic [25:0] size_bytes;
   } region_t;

endpackage

// [hw/region_size_decode.sv]
// Decodes the four-bit management region size code into a byte count.
// Purely combinational; fed from the low nibble of region byte C.
`timescale 1ns/1ns
module region_size_decode
   import core_cfg_pkg::*;
(
   input  wire logic [3:0]  size_code_i,
   output logic             enable_o,
   output logic [25:0]      size_bytes_o
);

   always_comb begin
      enable_o     = (size_code_i != SIZE_OFF);
      size_bytes_o = '0;
      if (size_code_i == SIZE_ALIAS) begin
         size_bytes_o = SIZE_MIN_BYTES;
      end else if (size_code_i != SIZE_OFF) begin
         size_bytes_o = SIZE_MIN_BYTES << (size_code_i - 4'h1);
      end
   end

endmodule

// [tb/core_clock_smm_region_id_regs_test.sv]
// Self-checking bench for the indexed core clock / region / ident bank.
// Drives the register port itself on falling edges; no partner model.
`timescale 1ns/1ns
module core_clock_smm_region_id_regs_test
   import core_cfg_pkg::*;
;
   localparam logic [7:0] PART = 8'ha7;  // Arbitrary value
   localparam logic [3:0] REV  = 4'h6;   // Arbitrary value
   localparam logic [3:0] STEP = 4'h9;   // Arbitrary value
   logic       clock_i;
   logic       reset_n_i;
   logic       ratio_strap_pin_i;
   logic       mgmt_mode_i;
   logic       bus_transfer_i;
   logic       index_wr_i;
   logic       data_wr_i;
   logic       data_rd_i;
   logic [7:0] wdata_i;
   logic [7:0] rdata_o;
   logic       rdata_valid_o;
   logic [1:0] core_ratio_o;
   logic       core_ratio_reserved_o;
   logic       core_half_o;
   logic       mgmt_lock_bit_o;
   logic [3:0] index_map_enable_o;
   region_t    mgmt_region_o;
   int         error_cnt = 0;
   int         n_tests = 0;
   int         cycles = 0;
   logic [7:0] rv;

   core_cfg_regs #(.PART_CODE(PART), .REVISION_CODE(REV), .STEPPING_CODE(STEP)) u_dut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .ratio_strap_pin_i(ratio_strap_pin_i),
      .mgmt_mode_i(mgmt_mode_i), .bus_transfer_i(bus_transfer_i), .index_wr_i(index_wr_i),
      .data_wr_i(data_wr_i), .data_rd_i(data_rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .rdata_valid_o(rdata_valid_o), .core_ratio_o(core_ratio_o),
      .core_ratio_reserved_o(core_ratio_reserved_o), .core_half_o(core_half_o),
      .mgmt_lock_bit_o(mgmt_lock_bit_o), .index_map_enable_o(index_map_enable_o),
      .mgmt_region_o(mgmt_region_o));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Strap only sampled after release, so it is set up while reset is low
   task automatic do_reset(input logic strap);
      reset_n_i = 1'b0;
      ratio_strap_pin_i = strap;
      repeat (12) @(negedge clock_i);
      reset_n_i = 1'b1;
      repeat (5) @(negedge clock_i);
   endtask

   task automatic set_index(input logic [7:0] idx);
      index_wr_i = 1'b1;
      wdata_i = idx;
      @(negedge clock_i);
      index_wr_i = 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      set_index(idx);
      data_wr_i = 1'b1;
      wdata_i = d;
      @(negedge clock_i);
      data_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      set_index(idx);
      data_rd_i = 1'b1;
      @(negedge clock_i);
      data_rd_i = 1'b0;
      check(rdata_valid_o, 1'b1);
      d = rdata_o;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset_ident;
      check(core_ratio_o, 2'h1);
      check(core_half_o, 1'b0);
      rd(IDX_PART_IDENT, rv);
      check(rv, PART);
      wr(IDX_PART_IDENT, ~PART);
      rd(IDX_PART_IDENT, rv);
      check(rv, PART);
      wr(IDX_REV_STEP_IDENT, 8'h00);
      rd(IDX_REV_STEP_IDENT, rv);
      check(rv[3:0], REV);
      check(rv[7:4], STEP);
      $display("reset and ident done");
   endtask

   task automatic t_power;
      logic [1:0] r;
      rd(IDX_POWER_CTL, rv);
      check(rv, 8'h00);
      wr(IDX_POWER_CTL, 8'h04);
      check(core_half_o, 1'b0);
      wr(IDX_CONFIG_CTL_THREE, 8'h10);
      check(index_map_enable_o, 4'h1);
      for (int i = 0; i < 4; i++) begin
         r = i[1:0];
         wr(IDX_POWER_CTL, {6'h3e, r});
         rd(IDX_POWER_CTL, rv);
         check(rv, {6'h00, r});
         check(core_ratio_o, r);
         check(core_ratio_reserved_o, r == 2'h2);
      end
      wr(IDX_POWER_CTL, 8'h04);
      check(core_half_o, 1'b1);
      @(negedge clock_i);
      check(core_half_o, 1'b1);
      // Two-cycle transfer; checks land mid-cycle, away from both edges
      bus_transfer_i = 1'b1;
      #2 check(core_half_o, 1'b0);
      @(negedge clock_i);
      #2 check(core_half_o, 1'b0);
      @(negedge clock_i);
      bus_transfer_i = 1'b0;
      #2 check(core_half_o, 1'b1);
      @(negedge clock_i);
      wr(IDX_POWER_CTL, 8'h01);
      check(core_ratio_o, 2'h1);
      check(core_half_o, 1'b0);
      $display("power control done");
   endtask

   task automatic t_region;
      logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'he, 4'hf};
      logic [25:0] sizes [6] = '{26'h0000000, 26'h0001000, 26'h0002000, 26'h0040000, 26'h2000000, 26'h0001000};
      wr(IDX_REGION_BYTE_A, 8'ha5);
      wr(IDX_REGION_BYTE_B, 8'h3c);
      foreach (codes[i]) begin
         wr(IDX_REGION_BYTE_C, {4'h9, codes[i]});
         check(mgmt_region_o.base, {16'ha53c, 4'h9});
         check(mgmt_region_o.enable, codes[i] != 4'h0);
         if (codes[i] != 4'h0) check(mgmt_region_o.size_bytes, sizes[i]);
      end
      rd(IDX_REGION_BYTE_B, rv);
      check(rv, 8'h3c);
      $display("region done");
   endtask

   task automatic t_lock;
      wr(IDX_CONFIG_CTL_THREE, 8'h11);
      check(mgmt_lock_bit_o, 1'b1);
      wr(IDX_REGION_BYTE_A, 8'h00);
      check(mgmt_region_o.base[19:12], 8'ha5);
      wr(IDX_CONFIG_CTL_THREE, 8'h13);
      rd(IDX_CONFIG_CTL_THREE, rv);
      check(rv, 8'h11);
      mgmt_mode_i = 1'b1;
      wr(IDX_REGION_BYTE_A, 8'h77);
      check(mgmt_region_o.base[19:12], 8'h77);
      wr(IDX_REGION_BYTE_B, 8'h5e);
      check(mgmt_region_o.base[11:4], 8'h5e);
      wr(IDX_CONFIG_CTL_THREE, 8'h12);
      rd(IDX_CONFIG_CTL_THREE, rv);
      check(rv, 8'h13);
      mgmt_mode_i = 1'b0;
      wr(IDX_CONFIG_CTL_THREE, 8'h10);
      rd(IDX_CONFIG_CTL_THREE, rv);
      check(rv, 8'h13);
      check(mgmt_lock_bit_o, 1'b1);
      do_reset(1'b1);
      check(mgmt_lock_bit_o, 1'b0);
      check(core_ratio_o, 2'h3);
      check(core_half_o, 1'b0);
      check(index_map_enable_o, 4'h0);
      $display("lock and strap done");
   endtask

   // -----------------------------------------------------------------
   // Main sequence and hang guard
   // -----------------------------------------------------------------
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      reset_n_i = 1'b0;
      ratio_strap_pin_i = 1'b0;
      mgmt_mode_i = 1'b0;
      bus_transfer_i = 1'b0;
      index_wr_i = 1'b0;
      data_wr_i = 1'b0;
      data_rd_i = 1'b0;
      wdata_i = 8'h00;
      do_reset(1'b0);
      t_reset_ident();
      t_power();
      t_region();
      t_lock();
      report_and_stop();
   end
endmodule
